// >>> asc_pkg.sv
// Shared constants and types for the converter control link
package asc_pkg;
  localparam int          FRAME_BITS     = 16;
  localparam logic [3:0]  LAST_BIT       = 4'hf;
  localparam logic [6:0]  CTRL_ADDR      = 7'h06;
  localparam int          SYNC_BIT       = 7;
  localparam int          ONESHOT_BIT    = 4;
  localparam int          SR_LSB         = 0;
  localparam logic [7:0]  CTRL_RESET     = 8'h80;
  localparam logic [1:0]  SR_FIRST       = 2'h3;
  localparam logic [1:0]  SR_SECOND      = 2'h2;
  localparam logic [15:0] RESET_ANSWER   = 16'h0e00;
  localparam logic [3:0]  SYNC_PULSE_CYC = 4'h4;
  localparam logic [3:0]  SYNC_GAP_CYC   = 4'h8;
  localparam logic [3:0]  DATA_READY_PIN_CYC       = 4'h4;
  localparam logic [3:0]  SCLK_HALF      = 4'h4;
  localparam logic [3:0]  INIT_TOGGLES   = 4'h8;
  localparam logic [3:0]  REG_CMD        = 4'h0;
  localparam logic [3:0]  REG_STATUS     = 4'h4;
  localparam logic [3:0]  REG_SYNC       = 4'h8;
  localparam logic [3:0]  REG_DATA       = 4'hc;
  localparam int          CNT_W          = 16;
  localparam int          SETTLE_CYC_DEF = 64;
  localparam int          ODR_CYC_DEF    = 32;

  typedef enum logic [1:0] {
    ASC_IDLE = 2'b00,
    ASC_LOW  = 2'b01,
    ASC_HIGH = 2'b10,
    ASC_GAP  = 2'b11
  } asc_spi_state_e;
endpackage

// >>> asc_link_if.sv
// Link between the converter control logic and its host controller
`timescale 1ns/1ns
interface asc_link_if;
  logic        sclk;
  logic        csN;
  logic        mosi;
  logic        miso;
  logic        syncOut;
  logic        syncIn;
  logic        dataReadyPin;
  logic [15:0] convData;

  modport dev (
    input  sclk,
    input  csN,
    input  mosi,
    input  syncIn,
    output miso,
    output syncOut,
    output dataReadyPin,
    output convData
  );

  modport host (
    output sclk,
    output csN,
    output mosi,
    output syncIn,
    input  miso,
    input  syncOut,
    input  dataReadyPin,
    input  convData
  );
endinterface

// >>> asc_device.sv
// Converter control register with sync, one-shot and soft reset logic
// Function
// - Sync bit rising acts as start pulse
// - Host writes sync bit 0, then 1
// - Writing sync bit 0 never triggers
// - Command taken at frame's last rising edge
// - Sync output looped back to sync input
// - Sync output may feed other devices
// - No data until filters have settled
// - Daisy chain needs two sync pulses
// - Shared clock, one ready pin: two pulses
// - One-shot: one result per sync rise
// - Reset needs 0x3 then 0x2 written
// - Completed reset restores core and registers
// - After reset answer next command 0x0E00
`timescale 1ns/1ns
module asc_device #(
  parameter int SETTLE_CYC = asc_pkg::SETTLE_CYC_DEF,
  parameter int ODR_CYC    = asc_pkg::ODR_CYC_DEF
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  asc_link_if.dev          link,
  input  wire logic [15:0] sampleIn,
  output logic             filterSettling
);
  typedef struct packed {
    logic        rstMeta;
    logic        rstSync;
    logic [3:0]  bitCnt;
    logic [15:0] shiftIn;
    logic [15:0] shiftOut;
    logic [7:0]  ctrl;
    logic        srArmed;
    logic        postReset;
    logic        syncTgl;
    logic        srTgl;
  } asc_spi_s;

  typedef struct packed {
    logic                       oneMeta;
    logic                       oneSync;
    logic                       synMeta;
    logic                       synSync;
    logic                       synPrev;
    logic                       srMeta;
    logic                       srSync;
    logic                       srPrev;
    logic                       inMeta;
    logic                       inSync;
    logic                       inPrev;
    logic [3:0]                 pulseCnt;
    logic                       syncOut;
    logic [asc_pkg::CNT_W-1:0]  settleCnt;
    logic [asc_pkg::CNT_W-1:0]  odrCnt;
    logic                       shotPending;
    logic [3:0]                 drdyCnt;
    logic                       dataReadyPin;
    logic [15:0]                convData;
    logic                       settling;
  } asc_core_s;

  localparam logic [asc_pkg::CNT_W-1:0] SETTLE_LOAD = asc_pkg::CNT_W'(SETTLE_CYC);
  localparam logic [asc_pkg::CNT_W-1:0] ODR_LAST    = asc_pkg::CNT_W'(ODR_CYC - 1);

  asc_spi_s  s;
  asc_spi_s  next_s;
  asc_core_s c;
  asc_core_s next_c;

  // Link side, clocked by the serial clock
  always_comb
  begin
    logic [15:0] word;
    logic [7:0]  rdData;
    logic [7:0]  newCtrl;
    logic [1:0]  srField;
    word    = {s.shiftIn[14:0], link.mosi};
    rdData  = 8'h00;
    newCtrl = word[7:0];
    srField = newCtrl[asc_pkg::SR_LSB +: 2];
    next_s  = s;
    next_s.rstMeta = rst_n;
    next_s.rstSync = s.rstMeta;
    if (!s.rstSync)
    begin
      next_s.bitCnt    = 4'h0;
      next_s.shiftIn   = 16'h0000;
      next_s.shiftOut  = 16'h0000;
      next_s.ctrl      = asc_pkg::CTRL_RESET;
      next_s.srArmed   = 1'b0;
      next_s.postReset = 1'b0;
      next_s.syncTgl   = 1'b0;
      next_s.srTgl     = 1'b0;
    end
    else if (!link.csN)
    begin
      next_s.shiftIn  = word;
      next_s.shiftOut = {s.shiftOut[14:0], 1'b0};
      next_s.bitCnt   = s.bitCnt + 4'h1;
      if (s.bitCnt == asc_pkg::LAST_BIT)
      begin
        if (word[14:8] == asc_pkg::CTRL_ADDR)
        begin
          rdData = s.ctrl;
        end
        next_s.postReset = 1'b0;
        // Answer shows the register before this frame's write
        next_s.shiftOut = s.postReset ? asc_pkg::RESET_ANSWER : {8'h00, rdData};
        if (!word[15] && word[14:8] == asc_pkg::CTRL_ADDR)
        begin
          next_s.ctrl = newCtrl;
          // Only a low-to-high change fires; a plain 0 just parks the bit
          if (!s.ctrl[asc_pkg::SYNC_BIT] && newCtrl[asc_pkg::SYNC_BIT])
          begin
            next_s.syncTgl = ~s.syncTgl;
          end
          if (srField == asc_pkg::SR_SECOND && s.srArmed)
          begin
            next_s.ctrl      = asc_pkg::CTRL_RESET;
            next_s.srTgl     = ~s.srTgl;
            next_s.syncTgl   = s.syncTgl;
            next_s.postReset = 1'b1;
            next_s.srArmed   = 1'b0;
          end
          else
          begin
            next_s.srArmed = (srField == asc_pkg::SR_FIRST);
          end
        end
      end
    end
  end

  always_ff @(posedge link.sclk)
  begin
    s <= next_s;
  end

  // Core side, clocked by the master clock
  always_comb
  begin
    logic coreRst;
    logic inRise;
    logic tick;
    coreRst = !rst_n || (c.srSync != c.srPrev);
    inRise  = c.inSync && !c.inPrev;
    tick    = (c.odrCnt == ODR_LAST);
    next_c  = c;
    if (coreRst)
    begin
      next_c = '0;
    end
    else
    begin
      if (c.synSync != c.synPrev)
      begin
        next_c.pulseCnt = asc_pkg::SYNC_PULSE_CYC;
      end
      else if (c.pulseCnt != 4'h0)
      begin
        next_c.pulseCnt = c.pulseCnt - 4'h1;
      end
      next_c.syncOut = (next_c.pulseCnt != 4'h0);

      next_c.odrCnt = tick ? '0 : c.odrCnt + 1'b1;
      if (inRise)
      begin
        // Every rising edge of the sync input restarts the filters, so rate counting restarts too
        next_c.settleCnt   = SETTLE_LOAD;
        next_c.odrCnt      = '0;
        next_c.shotPending = c.oneSync;
      end
      else if (c.settleCnt != '0)
      begin
        next_c.settleCnt = c.settleCnt - 1'b1;
      end

      if (!inRise && tick && c.settleCnt == '0 && (!c.oneSync || c.shotPending))
      begin
        next_c.convData    = sampleIn;
        next_c.drdyCnt     = asc_pkg::DATA_READY_PIN_CYC;
        next_c.shotPending = 1'b0;
      end
      else if (c.drdyCnt != 4'h0)
      begin
        next_c.drdyCnt = c.drdyCnt - 4'h1;
      end
      // Strobe spans several cycles so a two-stage receiver cannot miss it
      next_c.dataReadyPin = (next_c.drdyCnt != 4'h0);
      next_c.settling     = (next_c.settleCnt != '0);
    end
    next_c.oneMeta = s.ctrl[asc_pkg::ONESHOT_BIT];
    next_c.oneSync = c.oneMeta;
    next_c.synMeta = s.syncTgl;
    next_c.synSync = c.synMeta;
    next_c.synPrev = c.synSync;
    next_c.srMeta  = s.srTgl;
    next_c.srSync  = c.srMeta;
    next_c.srPrev  = c.srSync;
    next_c.inMeta  = link.syncIn;
    next_c.inSync  = c.inMeta;
    next_c.inPrev  = c.inSync;
  end

  always_ff @(posedge clk)
  begin
    c <= next_c;
  end

  assign link.miso         = s.shiftOut[15];
  assign link.syncOut      = c.syncOut;
  assign link.dataReadyPin = c.dataReadyPin;
  assign link.convData     = c.convData;
  assign filterSettling    = c.settling;
endmodule

// >>> asc_host.sv
// Host controller: serial frames, sync pulses and data capture behind Avalon-MM
`timescale 1ns/1ns
module asc_host (
  input  wire logic        clk,
  input  wire logic        rst_n,
  asc_link_if.host         link,
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest
);
  typedef struct packed {
    asc_pkg::asc_spi_state_e state;
    logic                    sclk;
    logic                    csN;
    logic                    mosi;
    logic [3:0]              bitIdx;
    logic [3:0]              phase;
    logic [3:0]              initCnt;
    logic [15:0]             shiftOut;
    logic [15:0]             shiftIn;
    logic [15:0]             resp;
    logic                    misoMeta;
    logic                    misoSync;
    logic                    soMeta;
    logic                    soSync;
    logic                    ownSync;
    logic [1:0]              pulsesLeft;
    logic [3:0]              pulseCnt;
    logic                    syncIn;
    logic                    drMeta;
    logic                    drSync;
    logic                    drPrev;
    logic [15:0]             conv;
    logic                    dataNew;
    logic                    waitrequest;
    logic [31:0]             readdata;
  } asc_host_s;

  asc_host_s h;
  asc_host_s next_h;

  always_comb
  begin
    logic halfDone;
    logic pulseIdle;
    logic serve;
    halfDone  = (h.phase == asc_pkg::SCLK_HALF - 4'h1);
    pulseIdle = (h.pulsesLeft == 2'h0) && !h.ownSync;
    serve     = 1'b0;
    next_h    = h;
    if (!rst_n)
    begin
      next_h         = '0;
      // Keeps the serial clock running so the far end sees its reset;
      // toggling waits for csN to be known so the clock starts defined
      if (h.csN)
      begin
        next_h.sclk = ~h.sclk;
      end
      next_h.csN     = 1'b1;
      next_h.initCnt = asc_pkg::INIT_TOGGLES;
      next_h.waitrequest = 1'b1;
    end
    else
    begin
      next_h.phase = h.phase + 4'h1;
      if (h.initCnt != 4'h0)
      begin
        next_h.initCnt = h.initCnt - 4'h1;
        // Last toggle parks the clock low, whatever the reset length was
        next_h.sclk    = (h.initCnt == 4'h1) ? 1'b0 : ~h.sclk;
      end
      case (h.state)
        asc_pkg::ASC_LOW:
          if (halfDone)
          begin
            next_h.sclk    = 1'b1;
            next_h.phase   = 4'h0;
            next_h.shiftIn = {h.shiftIn[14:0], h.misoSync};
            next_h.state   = asc_pkg::ASC_HIGH;
          end
        asc_pkg::ASC_HIGH:
          if (halfDone)
          begin
            next_h.sclk  = 1'b0;
            next_h.phase = 4'h0;
            if (h.bitIdx == asc_pkg::LAST_BIT)
            begin
              next_h.state = asc_pkg::ASC_GAP;
            end
            else
            begin
              next_h.bitIdx   = h.bitIdx + 4'h1;
              next_h.shiftOut = {h.shiftOut[14:0], 1'b0};
              next_h.mosi     = h.shiftOut[14];
              next_h.state    = asc_pkg::ASC_LOW;
            end
          end
        asc_pkg::ASC_GAP:
          if (halfDone)
          begin
            next_h.phase = 4'h0;
            next_h.csN   = 1'b1;
            if (h.csN)
            begin
              next_h.resp  = h.shiftIn;
              next_h.state = asc_pkg::ASC_IDLE;
            end
          end
        default:
          next_h.phase = 4'h0;
      endcase

      if (h.pulseCnt != 4'h0)
      begin
        next_h.pulseCnt = h.pulseCnt - 4'h1;
      end
      else if (h.ownSync)
      begin
        next_h.ownSync    = 1'b0;
        next_h.pulsesLeft = h.pulsesLeft - 2'h1;
        next_h.pulseCnt   = asc_pkg::SYNC_GAP_CYC - 4'h1;
      end
      else if (h.pulsesLeft != 2'h0)
      begin
        next_h.ownSync  = 1'b1;
        next_h.pulseCnt = asc_pkg::SYNC_PULSE_CYC - 4'h1;
      end

      if (h.drSync && !h.drPrev)
      begin
        next_h.conv    = link.convData;
        next_h.dataNew = 1'b1;
      end

      next_h.waitrequest = 1'b1;
      if (h.waitrequest && (read || write))
      begin
        next_h.readdata = 32'h0000_0000;
        case (address)
          asc_pkg::REG_CMD:
            // Each command is its own frame, so the two sync writes stay separate
            if (!write || (h.state == asc_pkg::ASC_IDLE && h.initCnt == 4'h0))
            begin
              serve = 1'b1;
              if (write)
              begin
                next_h.shiftOut = writedata[15:0];
                next_h.mosi     = writedata[15];
                next_h.csN      = 1'b0;
                next_h.bitIdx   = 4'h0;
                next_h.phase    = 4'h0;
                next_h.state    = asc_pkg::ASC_LOW;
              end
            end
          asc_pkg::REG_SYNC:
            if (!write || pulseIdle)
            begin
              serve = 1'b1;
              if (write && writedata[0])
              begin
                next_h.pulsesLeft = 2'h2;
              end
            end
          asc_pkg::REG_STATUS:
          begin
            serve = 1'b1;
            next_h.readdata = {h.resp, 14'h0000, h.dataNew, (h.state != asc_pkg::ASC_IDLE)};
          end
          asc_pkg::REG_DATA:
          begin
            serve = 1'b1;
            next_h.readdata = {16'h0000, h.conv};
            if (read && !(h.drSync && !h.drPrev))
            begin
              next_h.dataNew = 1'b0;
            end
          end
          default:
            serve = 1'b1;
        endcase
        next_h.waitrequest = !serve;
      end
    end
    next_h.misoMeta = link.miso;
    next_h.misoSync = h.misoMeta;
    next_h.soMeta   = link.syncOut;
    next_h.soSync   = h.soMeta;
    next_h.drMeta   = link.dataReadyPin;
    next_h.drSync   = h.drMeta;
    next_h.drPrev   = h.drSync;
    next_h.syncIn   = rst_n && (h.ownSync || h.soSync);
  end

  always_ff @(posedge clk)
  begin
    h <= next_h;
  end

  assign link.sclk   = h.sclk;
  assign link.csN    = h.csN;
  assign link.mosi   = h.mosi;
  assign link.syncIn = h.syncIn;
  assign readdata    = h.readdata;
  assign waitrequest = h.waitrequest;
endmodule

// >>> asc_assertions.sv
// Concurrent checks on the converter control link
`timescale 1ns/1ns
module asc_assertions #(
  parameter int SETTLE_CYC = 64
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic csN,
  input wire logic mosi,
  input wire logic syncOut,
  input wire logic syncIn,
  input wire logic dataReadyPin
);
  logic [4:0]  edgeCnt;
  logic [15:0] sinceSync;
  logic        sclkD;
  logic        syncInD;
  logic        syncInD2;
  logic        syncInD3;

  // Saturates so that data long after the last sync is never flagged
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      edgeCnt <= 5'h0;
      sinceSync <= 16'hffff;
      sclkD <= 1'b0;
      syncInD <= 1'b0;
      syncInD2 <= 1'b0;
      syncInD3 <= 1'b0;
    end
    else
    begin
      sclkD <= sclk;
      syncInD <= syncIn;
      syncInD2 <= syncInD;
      syncInD3 <= syncInD2;
      if (csN)
        edgeCnt <= 5'h0;
      else if (sclk && !sclkD)
        edgeCnt <= edgeCnt + 5'h1;
      // Counts from where the device's two-flop input sees the edge
      if (syncInD2 && !syncInD3)
        sinceSync <= 16'h0;
      else if (sinceSync != 16'hffff)
        sinceSync <= sinceSync + 16'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_sync_width; $rose(syncOut) |-> syncOut [*4] ##1 !syncOut; endproperty
  a_sync_width: assert property (p_sync_width) else $error("sync output pulse width wrong");
  property p_sync_after_frame; $rose(syncOut) |-> (csN || edgeCnt == 5'h10); endproperty
  a_sync_after_frame: assert property (p_sync_after_frame) else $error("sync output inside a frame");
  property p_loopback; $rose(syncOut) |-> ##[1:6] syncIn; endproperty
  a_loopback: assert property (p_loopback) else $error("sync output not looped back");
  property p_sync_in_width; $rose(syncIn) |-> syncIn [*4]; endproperty
  a_sync_in_width: assert property (p_sync_in_width) else $error("sync input pulse too short");
  property p_settle; $rose(dataReadyPin) |-> sinceSync >= SETTLE_CYC; endproperty
  a_settle: assert property (p_settle) else $error("data before filters settled");
  property p_ready_width; $rose(dataReadyPin) |-> dataReadyPin [*4] ##1 !dataReadyPin; endproperty
  a_ready_width: assert property (p_ready_width) else $error("ready strobe width wrong");
  property p_frame_len; $rose(csN) |-> edgeCnt == 5'h10; endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame not sixteen clocks");
  property p_mosi_hold; (!csN && sclk && $past(sclk)) |-> $stable(mosi); endproperty
  a_mosi_hold: assert property (p_mosi_hold) else $error("host data moved while clock high");

  c_sync: cover property ($rose(syncOut));
  c_ready: cover property ($rose(dataReadyPin));
  c_pair: cover property ($rose(syncIn) ##[1:20] $rose(syncIn));
endmodule

// >>> adc_sync_oneshot_softreset_ctrl_tb.sv
// Self-checking bench joining the converter and its host controller
`timescale 1ns/1ns
`define CHK(n,e,s) begin totalChecks++; if ((e) !== (s)) begin errTotal++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module adc_sync_oneshot_softreset_ctrl_tb;
  localparam int SETTLE = 40;
  localparam int ODR    = 16;
  logic        clk;
  logic        rst_n;
  logic [3:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [15:0] sampleIn;
  logic        filterSettling;
  logic [31:0] rdv;
  logic [31:0] rnd;
  logic [31:0] eV;
  logic [31:0] mV;
  logic        chkOn;
  logic [2:0]  prev;
  logic [31:0] expQ[$];
  logic [31:0] mskQ[$];
  int          errTotal;
  int          totalChecks;
  int          syncCnt;
  int          readyCnt;
  int          sinCnt;
  int          n;

  asc_link_if link ();
  asc_device #(.SETTLE_CYC(SETTLE), .ODR_CYC(ODR)) asc_device_inst (.clk(clk), .rst_n(rst_n), .link(link),
    .sampleIn(sampleIn), .filterSettling(filterSettling));
  asc_host asc_host_inst (.clk(clk), .rst_n(rst_n), .link(link), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));
  asc_assertions #(.SETTLE_CYC(SETTLE)) asc_assertions_inst (.clk(clk), .rst_n(rst_n), .sclk(link.sclk),
    .csN(link.csN), .mosi(link.mosi), .syncOut(link.syncOut), .syncIn(link.syncIn),
    .dataReadyPin(link.dataReadyPin));

  always #10 clk = ~clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic summarize;
    $display("checks %0d errors %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge clk);
  endtask

  // Request held until waitrequest is sampled low; released on that edge
  task automatic avXfer(input logic [3:0] a, input logic w, input logic [31:0] d, input logic c);
    @(posedge clk);
    address <= a;
    write <= w;
    read <= !w;
    writedata <= d;
    chkOn <= c;
    do
    begin
      @(posedge clk);
    end
    while (waitrequest !== 1'b0);
    rdv = readdata;
    read <= 1'b0;
    write <= 1'b0;
    chkOn <= 1'b0;
  endtask

  task automatic checkRd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    expQ.push_back(e);
    mskQ.push_back(m);
    avXfer(a, 1'b0, 32'h0, 1'b1);
  endtask

  // Polls busy so that each frame has finished before the next step
  task automatic frame(input logic [15:0] w);
    avXfer(asc_pkg::REG_CMD, 1'b1, {16'h0, w}, 1'b0);
    do
    begin
      avXfer(asc_pkg::REG_STATUS, 1'b0, 32'h0, 1'b0);
    end
    while (rdv[0] !== 1'b0);
  endtask

  task automatic resp(input logic [15:0] w);
    checkRd(asc_pkg::REG_STATUS, {w, 16'h0}, 32'hffff0000);
  endtask

  always @(posedge clk)
  begin
    prev <= {link.syncOut, link.dataReadyPin, link.syncIn};
    if (link.syncOut && !prev[2])
      syncCnt++;
    if (link.dataReadyPin && !prev[1])
      readyCnt++;
    if (link.syncIn && !prev[0])
      sinCnt++;
    if (read && waitrequest === 1'b0 && chkOn)
    begin
      eV = expQ.pop_front();
      mV = mskQ.pop_front();
      `CHK("readdata", eV, readdata & mV)
    end
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    errTotal++;
    summarize();
  end

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    {address, read, write, writedata, sampleIn, chkOn} = '0;
    rnd = 32'd56341;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    checkRd(4'h2, 32'h0, 32'hffffffff);
    avXfer(asc_pkg::REG_STATUS, 1'b1, 32'hffffffff, 1'b0);
    frame(16'h8600);
    frame(16'h8600);
    resp(16'h0080);
    rnd = xs(rnd);
    sampleIn <= rnd[15:0];
    n = syncCnt;
    frame(16'h0600);
    idle(40);
    `CHK("sync count", n, syncCnt)
    frame(16'h0680);
    idle(40);
    `CHK("sync count", n + 1, syncCnt)
    while (link.dataReadyPin !== 1'b1)
    begin
      @(posedge clk);
    end
    idle(6);
    checkRd(asc_pkg::REG_DATA, {16'h0, sampleIn}, 32'h0000ffff);
    frame(16'h0610);
    rnd = xs(rnd);
    sampleIn <= rnd[15:0];
    frame(16'h0690);
    n = readyCnt;
    `CHK("settling", 1'b1, filterSettling)
    idle(SETTLE + 6 * ODR);
    `CHK("settling", 1'b0, filterSettling)
    `CHK("result count", n + 1, readyCnt)
    checkRd(asc_pkg::REG_DATA, {16'h0, sampleIn}, 32'h0000ffff);
    frame(16'h0680);
    n = sinCnt;
    avXfer(asc_pkg::REG_SYNC, 1'b1, 32'h1, 1'b0);
    idle(60);
    `CHK("sync in count", n + 2, sinCnt)
    frame(16'h0603);
    frame(16'h0601);
    frame(16'h0602);
    frame(16'h8600);
    frame(16'h8600);
    resp(16'h0002);
    // Soft reset sent with one-shot set: next answer 0x0E00, then control reads 0x80
    frame(16'h0613);
    frame(16'h0612);
    frame(16'h8600);
    frame(16'h8600);
    resp(16'h0e00);
    frame(16'h8600);
    resp(16'h0080);
    summarize();
  end
endmodule
